//--- oss_pkg.sv
// Constants and types shared by the oscillator source switch
package oss_pkg;

  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_TRIM   = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h08;

  // Status register fields
  localparam int unsigned STAT_REQ_BIT  = 0;
  localparam int unsigned STAT_ENG_BIT  = 1;

  // Control register fields
  localparam int unsigned CTRL_SEL_LSB  = 0;
  localparam int unsigned CTRL_SEL_W    = 2;
  localparam int unsigned CTRL_PIN2_BIT = 2;

  localparam int unsigned TRIM_W        = 8;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h80;

  // Rising external edges seen before the handover
  localparam int unsigned EDGE_CNT_W    = 2;
  localparam logic [EDGE_CNT_W-1:0] EDGES_NEEDED = 2'h2;

  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'b00,
    SRC_EXT_CLK  = 2'b01,
    SRC_RC       = 2'b10,
    SRC_CRYSTAL  = 2'b11
  } oss_src_t;

  typedef enum logic [1:0] {
    ST_INTERNAL = 2'b00,
    ST_CHECK    = 2'b01,
    ST_HANDOVER = 2'b10,
    ST_EXTERNAL = 2'b11
  } oss_state_t;

  localparam oss_src_t SEL_RESET = SRC_INTERNAL;

endpackage : oss_pkg

//--- oss_clk_if.sv
// Signals between the switch controller and its clock helpers
`timescale 1ns/1ns
`default_nettype none
interface oss_clk_if;
  logic extLevel;
  logic extSync;
  logic checkEnable;
  logic edgesSeen;
  logic srcLevel;
  logic clockRun;
  logic quadClk;
  logic doubleClk;

  modport ctrl (output extLevel, output checkEnable, output srcLevel, output clockRun,
                input extSync, input edgesSeen, input quadClk, input doubleClk);
  modport check (input extLevel, input checkEnable, output extSync, output edgesSeen);
  modport gen (input srcLevel, input clockRun, output quadClk, output doubleClk);
endinterface : oss_clk_if
`default_nettype wire

//--- oss_edge_check.sv
// Synchroniser and two-edge activity check on the external source
`timescale 1ns/1ns
`default_nettype none
module oss_edge_check
  import oss_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  oss_clk_if.check ck
);

  logic                  meta_q;
  logic                  sync_q;
  logic                  prev_q;
  logic [EDGE_CNT_W-1:0] cnt_q;
  logic [EDGE_CNT_W-1:0] cnt_d;
  wire                   riseSeen = sync_q & ~prev_q;

  // first flop only feeds the second
  always_ff @(posedge clk) begin
    meta_q <= ck.extLevel;
    sync_q <= meta_q;
    prev_q <= sync_q;
  end

  // count two rising edges, restart when disabled
  assign cnt_d = !ck.checkEnable ? '0 :
                 (riseSeen && cnt_q != EDGES_NEEDED) ? cnt_q + 2'h1 : cnt_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign ck.extSync   = sync_q;
  assign ck.edgesSeen = (cnt_q == EDGES_NEEDED);

endmodule : oss_edge_check
`default_nettype wire

//--- oss_clk_gen.sv
// Quad-rate and double-rate clock generation from the selected source
`timescale 1ns/1ns
`default_nettype none
module oss_clk_gen
  import oss_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  oss_clk_if.gen   gn
);

  logic quad_q;
  logic dbl_q;
  logic run_q;
  wire  quadLow = ~quad_q & ~gn.srcLevel;
  // Gate only changes while the output is low, so no pulse is cut short
  wire  run_d   = quadLow ? gn.clockRun : run_q;
  wire  quad_d  = run_q & gn.srcLevel;
  wire  quadRise = quad_d & ~quad_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run_q  <= 1'b0;
      quad_q <= 1'b0;
      dbl_q  <= 1'b0;
    end else begin
      run_q  <= run_d;
      quad_q <= quad_d;
      dbl_q  <= quadRise ? ~dbl_q : dbl_q;
    end
  end

  assign gn.quadClk   = quad_q;
  assign gn.doubleClk = dbl_q;

endmodule : oss_clk_gen
`default_nettype wire

//--- oss_switch_top.sv
// Oscillator source selection, glitch-free handover and APB registers
//
// Notes on behaviour
// - two-bit select picks one of four sources
// - external select makes first pin clock input
// - two external rising edges before switching
// - handover without glitch or short pulse
// - set engaged flag, then stop internal oscillator
// - internal oscillator returns only through reset
// - internal/RC: pin two is port bit or clock
// - external/crystal modes ignore pin two enable
// - enable signal gates the oscillator in use
// - quad-rate clock equals source rate
// - double-rate clock is half quad-rate
// - wait mode leaves clocks running
// - stop mode stops source and derived clocks
// - break state keeps both clocks running
// - request bit RW, reset zero, ignored in test/monitor
// - engaged bit read-only, one while external drives
// - trim factor RW, resets to 80 hex
// - internal oscillator selected out of reset
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module oss_switch_top
  import oss_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Source clocks, sampled levels
  input  wire logic              internalOscClock,
  input  wire logic              rcNetworkClock,
  input  wire logic              crystalClock,
  input  wire logic              firstPinIn,
  // System integration controls
  input  wire logic              oscillatorEnableSignal,
  input  wire logic              waitMode,
  input  wire logic              stopMode,
  input  wire logic              breakState,
  input  wire logic              monitorBypass,
  input  wire logic              firstTestMode,
  input  wire logic              secondTestMode,
  // Port A bit 4 as seen by the port logic
  input  wire logic              portABit4Out,
  input  wire logic              portABit4Oe,
  output logic                   portABit4In,
  // Second oscillator pin
  input  wire logic              pin2In,
  output logic                   pin2Out,
  output logic                   pin2Oe,
  // Oscillator outputs
  output logic                   firstPinIsClockIn,
  output logic                   internalOscRun,
  output logic                   rcOscRun,
  output logic                   crystalOscRun,
  output logic      [TRIM_W-1:0] trimFactor,
  output logic                   quadRateClock,
  output logic                   doubleRateClock
);

  function automatic logic isExternal(input oss_src_t s);
    isExternal = (s != SRC_INTERNAL);
  endfunction : isExternal

  oss_clk_if ck ();

  oss_state_t       state_q;
  oss_state_t       state_d;
  oss_src_t         sel_q;
  logic             pin2En_q;
  logic             req_q;
  logic             engaged_q;
  logic             useExt_q;
  logic             intRun_q;
  logic [TRIM_W-1:0] trim_q;
  logic [DATA_W-1:0] rdata_q;

  // ---------------- Bus decode ----------------
  wire setupPhase = psel & ~penable;
  wire accessDone = psel & penable;
  wire hitStatus  = (paddr == ADDR_STATUS);
  wire hitTrim    = (paddr == ADDR_TRIM);
  wire hitCtrl    = (paddr == ADDR_CTRL);
  wire mapped     = hitStatus | hitTrim | hitCtrl;
  wire wrStatus   = accessDone & pwrite & hitStatus;
  wire wrTrim     = accessDone & pwrite & hitTrim;
  wire wrCtrl     = accessDone & pwrite & hitCtrl;

  wire [DATA_W-1:0] statusWord = {{(DATA_W-2){1'b0}}, engaged_q, req_q};
  wire [DATA_W-1:0] trimWord   = {{(DATA_W-TRIM_W){1'b0}}, trim_q};
  wire [DATA_W-1:0] ctrlWord   = {{(DATA_W-3){1'b0}}, pin2En_q, sel_q};
  wire [DATA_W-1:0] readMux    = hitStatus ? statusWord :
                                 hitTrim   ? trimWord   :
                                 hitCtrl   ? ctrlWord   : '0;

  // Zero wait states; data is staged in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = accessDone & ~mapped;
  assign prdata  = rdata_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else if (setupPhase && !pwrite) begin
      rdata_q <= readMux;
    end
  end

  // ---------------- Configuration registers ----------------
  // select resets to internal; changes are locked once a request leaves the internal state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sel_q    <= SEL_RESET;
      pin2En_q <= 1'b0;
    end else if (wrCtrl) begin
      if (state_q == ST_INTERNAL) begin
        sel_q <= oss_src_t'(pwdata[CTRL_SEL_LSB +: CTRL_SEL_W]);
      end
      pin2En_q <= pwdata[CTRL_PIN2_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      trim_q <= TRIM_RESET;
    end else if (wrTrim) begin
      trim_q <= pwdata[TRIM_W-1:0];
    end
  end

  // request bit is plain read/write storage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      req_q <= 1'b0;
    end else if (wrStatus) begin
      req_q <= pwdata[STAT_REQ_BIT];
    end
  end

  // request has no effect in monitor bypass or test modes
  wire reqBlocked   = monitorBypass | firstTestMode | secondTestMode;
  wire reqEffective = req_q & ~reqBlocked & isExternal(sel_q);

  // ---------------- Handover sequencer ----------------
  wire curSrcLow = useExt_q ? ~ck.extSync : ~internalOscClock;
  wire bothLow   = ~ck.quadClk & ~ck.extSync & curSrcLow;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_INTERNAL: begin
        if (reqEffective) begin
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (!reqEffective) begin
          state_d = ST_INTERNAL;
        end else if (ck.edgesSeen) begin
          state_d = ST_HANDOVER;
        end
      end
      // move only while old source, new source and output are all low
      ST_HANDOVER: begin
        if (bothLow) begin
          state_d = ST_EXTERNAL;
        end
      end
      // no way back except reset, even if the source dies
      ST_EXTERNAL: begin
        state_d = ST_EXTERNAL;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ST_INTERNAL;
    end else begin
      state_q <= state_d;
    end
  end

  wire switchNow = (state_q == ST_HANDOVER) && bothLow;

  // the output source flips at a low point of every clock involved
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      useExt_q <= 1'b0;
    end else if (switchNow) begin
      useExt_q <= 1'b1;
    end
  end

  // engaged is set with the switch, the internal oscillator stops after
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      engaged_q <= 1'b0;
    end else if (switchNow) begin
      engaged_q <= 1'b1;
    end
  end

  // internal oscillator runs from reset until one cycle after engaged
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      intRun_q <= 1'b1;
    end else if (engaged_q) begin
      intRun_q <= 1'b0;
    end
  end

  // ---------------- External source selection ----------------
  // the external level comes from the source that the select names
  always_comb begin
    unique case (sel_q)
      SRC_EXT_CLK: ck.extLevel = firstPinIn;
      SRC_RC:      ck.extLevel = rcNetworkClock;
      SRC_CRYSTAL: ck.extLevel = crystalClock;
      SRC_INTERNAL: ck.extLevel = 1'b0;
    endcase
  end

  // counting starts once the request is accepted
  assign ck.checkEnable = (state_q == ST_CHECK);

  // source seen by the output stage
  assign ck.srcLevel = useExt_q ? ck.extSync : internalOscClock;

  // stop mode or enable low halts; wait and break do not
  // waitMode and breakState deliberately leave the clocks alone
  wire srcAllowed = oscillatorEnableSignal & ~stopMode;
  assign ck.clockRun = srcAllowed;

  oss_edge_check u_edge (
    .clk     (clk),
    .reset_n (reset_n),
    .ck      (ck.check)
  );

  oss_clk_gen u_gen (
    .clk     (clk),
    .reset_n (reset_n),
    .gn      (ck.gen)
  );

  assign quadRateClock   = ck.quadClk;
  assign doubleRateClock = ck.doubleClk;

  // enable reaches all three oscillator run outputs
  assign internalOscRun = intRun_q & srcAllowed;
  assign rcOscRun       = (sel_q == SRC_RC) & srcAllowed;
  assign crystalOscRun  = (sel_q == SRC_CRYSTAL) & srcAllowed;

  assign trimFactor = trim_q;

  // external select turns the first pin into the clock input
  assign firstPinIsClockIn = isExternal(sel_q);

  // ---------------- Second oscillator pin ----------------
  // pin function by mode; enable bit counts only for internal and RC
  wire pin2Crystal = (sel_q == SRC_CRYSTAL);
  wire pin2ClkOut  = ((sel_q == SRC_INTERNAL) || (sel_q == SRC_RC)) && pin2En_q;
  wire pin2IsPort  = ~pin2Crystal & ~pin2ClkOut;

  always_comb begin
    if (pin2Crystal) begin
      // inverting amplifier output, active while the crystal runs
      pin2Out = ~firstPinIn;
      pin2Oe  = crystalOscRun;
    end else if (pin2ClkOut) begin
      pin2Out = ck.quadClk;
      pin2Oe  = 1'b1;
    end else begin
      pin2Out = portABit4Out;
      pin2Oe  = portABit4Oe;
    end
  end

  // Port logic reads zero while the pin serves the oscillator
  assign portABit4In = pin2IsPort & pin2In;

endmodule : oss_switch_top
`default_nettype wire

//--- oss_switch_top_properties.sv
// Port-level checks on the oscillator source switch
`timescale 1ns/1ns
`default_nettype none
module oss_switch_props
  import oss_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic              internalOscClock,
  input wire logic              firstPinIn,
  input wire logic              oscillatorEnableSignal,
  input wire logic              waitMode,
  input wire logic              stopMode,
  input wire logic              breakState,
  input wire logic              pin2Out,
  input wire logic              pin2Oe,
  input wire logic              firstPinIsClockIn,
  input wire logic              internalOscRun,
  input wire logic              rcOscRun,
  input wire logic              crystalOscRun,
  input wire logic [TRIM_W-1:0] trimFactor,
  input wire logic              quadRateClock,
  input wire logic              doubleRateClock
);
  logic quad1_q;
  logic quad2_q;
  logic intOff_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk) begin
    quad1_q <= quadRateClock;
    quad2_q <= quad1_q;
  end
  // Internal oscillator dropped while enabled means the handover finished
  always_ff @(posedge clk) begin
    if (!reset_n) intOff_q <= 1'b0;
    else if ($fell(internalOscRun) && oscillatorEnableSignal && !stopMode) intOff_q <= 1'b1;
  end
  sequence s_stop_held; stopMode [*8]; endsequence
  sequence s_int_run; (internalOscRun && !firstPinIsClockIn) [*8]; endsequence
  property p_trim_rst; $rose(reset_n) |-> trimFactor == TRIM_RESET; endproperty
  property p_trim_wr; psel && penable && pwrite && paddr == ADDR_TRIM |=> trimFactor == $past(pwdata[7:0]); endproperty
  property p_double; $changed(doubleRateClock) |-> (quadRateClock && !quad1_q) || (quad1_q && !quad2_q); endproperty
  property p_stop; s_stop_held |-> !quadRateClock && $stable(doubleRateClock); endproperty
  property p_wait; (waitMode || breakState) && oscillatorEnableSignal && !stopMode |-> ##[1:10] $changed(quadRateClock);
  endproperty
  property p_xtal; crystalOscRun |-> pin2Oe && pin2Out == !firstPinIn; endproperty
  property p_gate; !oscillatorEnableSignal || stopMode |-> !internalOscRun && !rcOscRun && !crystalOscRun; endproperty
  property p_int_off; intOff_q |-> !internalOscRun; endproperty
  property p_quad_int; s_int_run |-> quadRateClock == $past(internalOscClock); endproperty
  a_trim_rst: assert property (p_trim_rst) else $error("trim reset value wrong");
  a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");
  a_double: assert property (p_double) else $error("double clock not tied to quad rise");
  a_stop: assert property (p_stop) else $error("clocks run in stop");
  a_wait: assert property (p_wait) else $error("clocks halted in wait or break");
  a_xtal: assert property (p_xtal) else $error("pin two not inverting first pin");
  a_gate: assert property (p_gate) else $error("oscillator runs while disabled");
  a_int_off: assert property (p_int_off) else $error("internal oscillator restarted");
  a_quad_int: assert property (p_quad_int) else $error("quad clock not following source");
endmodule : oss_switch_props
bind oss_switch_top oss_switch_props u_props (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .internalOscClock, .firstPinIn, .oscillatorEnableSignal, .waitMode, .stopMode, .breakState, .pin2Out,
  .pin2Oe, .firstPinIsClockIn, .internalOscRun, .rcOscRun, .crystalOscRun, .trimFactor, .quadRateClock,
  .doubleRateClock);
`default_nettype wire

//--- oss_src_model.sv
// Behavioural oscillators and external clock around the switch
`timescale 1ns/1ns
`default_nettype none
module oss_src_model (
  input  wire logic clk,
  input  wire logic internalOscRun,
  input  wire logic rcOscRun,
  input  wire logic crystalOscRun,
  input  wire logic extRun,
  output logic      internalOscClock,
  output logic      rcNetworkClock,
  output logic      crystalClock,
  output logic      firstPinIn
);
  int unsigned tick = 0;
  always @(posedge clk) tick <= tick + 1;
  assign internalOscClock = internalOscRun && (tick % 6 < 3);
  assign rcNetworkClock   = rcOscRun && (tick % 4 < 2);
  assign crystalClock     = crystalOscRun && ((tick + 1) % 6 < 3);
  // A dead external clock sits low
  assign firstPinIn       = extRun && ((tick + 2) % 6 < 3);
endmodule : oss_src_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the oscillator source switch
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import oss_pkg::*;
  logic              clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [2:0]        ph;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic              internalOscClock, rcNetworkClock, crystalClock, firstPinIn, extRun;
  logic              oscillatorEnableSignal, waitMode, stopMode, breakState;
  logic              monitorBypass, firstTestMode, secondTestMode, portABit4Out, portABit4Oe, portABit4In;
  logic              pin2In, pin2Out, pin2Oe, firstPinIsClockIn, internalOscRun, rcOscRun, crystalOscRun;
  logic              quadRateClock, doubleRateClock;
  logic [TRIM_W-1:0] trimFactor;
  int                mismatches = 0;
  int                checks_done = 0;
  oss_switch_top dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .internalOscClock, .rcNetworkClock, .crystalClock, .firstPinIn, .oscillatorEnableSignal, .waitMode,
    .stopMode, .breakState, .monitorBypass, .firstTestMode, .secondTestMode, .portABit4Out, .portABit4Oe,
    .portABit4In, .pin2In, .pin2Out, .pin2Oe, .firstPinIsClockIn, .internalOscRun, .rcOscRun,
    .crystalOscRun, .trimFactor, .quadRateClock, .doubleRateClock);
  oss_src_model src (.clk, .internalOscRun, .rcOscRun, .crystalOscRun, .extRun, .internalOscClock,
    .rcNetworkClock, .crystalClock, .firstPinIn);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; released after the edge that samples pready
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  initial begin
    #40000;
    mismatches++;
    end_sim();
  end
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, waitMode, stopMode, breakState, extRun} = '0;
    {monitorBypass, firstTestMode, secondTestMode, portABit4Out, portABit4Oe, pin2In} = '0;
    oscillatorEnableSignal = 1'b1;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdchk(ADDR_STATUS, 32'h0);
    rdchk(ADDR_TRIM, 32'h80);
    rdchk(ADDR_CTRL, 32'h0);
    chk(firstPinIsClockIn, 1'b0);
    xfer(ADDR_TRIM, 1'b1, 32'h5a);
    rdchk(ADDR_TRIM, 32'h5a);
    xfer(ADDR_STATUS, 1'b1, 32'h2);
    rdchk(ADDR_STATUS, 32'h0);
    xfer(8'h0c, 1'b0, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("registers done");
    portABit4Oe <= 1'b1;
    portABit4Out <= 1'b1;
    pin2In <= 1'b1;
    xfer(ADDR_CTRL, 1'b1, 32'h4);
    chk({pin2Oe, portABit4In}, 2'b10);
    xfer(ADDR_CTRL, 1'b1, 32'h0);
    chk({pin2Oe, pin2Out, portABit4In}, 3'b111);
    oscillatorEnableSignal <= 1'b0;
    portABit4Oe <= 1'b0;
    repeat (2) @(posedge clk);
    chk(internalOscRun, 1'b0);
    oscillatorEnableSignal <= 1'b1;
    repeat (12) @(posedge clk);
    // precharge: pin two driven high as a port output
    portABit4Oe <= 1'b1;
    portABit4Out <= 1'b1;
    repeat (4) @(posedge clk);
    chk({pin2Oe, pin2Out}, 2'b11);
    portABit4Oe <= 1'b0;
    for (int s = 1; s < 4; s++) begin
      xfer(ADDR_CTRL, 1'b1, 32'(s) | 32'h4);
      chk({firstPinIsClockIn, rcOscRun, crystalOscRun, pin2Oe}, {1'b1, s == 2, s == 3, s != 1});
      repeat (8) @(posedge clk);
    end
    $display("pin modes done");
    xfer(ADDR_CTRL, 1'b1, 32'h1);
    extRun <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      {monitorBypass, firstTestMode, secondTestMode} <= 3'(1 << i);
      xfer(ADDR_STATUS, 1'b1, 32'h1);
      repeat (40) @(posedge clk);
      rdchk(ADDR_STATUS, 32'h1);
      xfer(ADDR_STATUS, 1'b1, 32'h0);
    end
    {monitorBypass, firstTestMode, secondTestMode} <= 3'h0;
    extRun <= 1'b0;
    $display("ignored request done");
    repeat (20) @(posedge clk);
    xfer(ADDR_STATUS, 1'b1, 32'h1);
    repeat (40) @(posedge clk);
    rdchk(ADDR_STATUS, 32'h1);
    extRun <= 1'b1;
    for (int n = 0; n < 30 && rd[STAT_ENG_BIT] !== 1'b1; n++) xfer(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h3);
    repeat (2) @(posedge clk);
    chk(internalOscRun, 1'b0);
    xfer(ADDR_CTRL, 1'b1, 32'h2);
    rdchk(ADDR_CTRL, 32'h1);
    // External level passes two sync flops and the output flop
    ph = 3'h0;
    repeat (3) begin
      @(posedge clk);
      #1 ph = {ph[1:0], firstPinIn};
    end
    repeat (6) begin
      @(posedge clk);
      #1 chk(quadRateClock, ph[2]);
      ph = {ph[1:0], firstPinIn};
    end
    @(posedge clk);
    {waitMode, breakState} <= 2'b11;
    repeat (24) @(posedge clk);
    {waitMode, breakState} <= 2'b00;
    stopMode <= 1'b1;
    repeat (12) @(posedge clk);
    stopMode <= 1'b0;
    extRun <= 1'b0;
    repeat (30) @(posedge clk);
    rdchk(ADDR_STATUS, 32'h3);
    chk(internalOscRun, 1'b0);
    $display("handover done");
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdchk(ADDR_STATUS, 32'h0);
    chk(internalOscRun, 1'b1);
    $display("second reset done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
